// [hdl/rbo_pkg.sv]
// constants, register map and types for the relay bank output control block
package rbo_pkg;
    localparam int NUM_BANKS = 4;
    localparam int NUM_RELAYS = 24;
    // bank geometry: first bit of each bank in the 24-bit relay word
    localparam int BANK_FIRST_LSB = 0;
    localparam int BANK_SECOND_LSB = 8;
    localparam int BANK_CHIGH_LSB = 16;
    localparam int BANK_CLOW_LSB = 20;
    localparam logic [23:0] BANK_FIRST_MASK = 24'h0000ff;
    localparam logic [23:0] BANK_SECOND_MASK = 24'h00ff00;
    localparam logic [23:0] BANK_CHIGH_MASK = 24'h0f0000;
    localparam logic [23:0] BANK_CLOW_MASK = 24'hf00000;
    // register byte offsets
    localparam logic [7:0] REG_RELAY_DATA = 8'h00;
    localparam logic [7:0] REG_STRAPS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_LINK_CTRL = 8'h14;
    // status / interrupt bit positions
    localparam int ST_POWER_GOOD = 0;
    localparam int ST_LINK_UP = 1;
    localparam int ST_BANK_WRITTEN = 4;
    localparam int IRQ_POWER_FAULT = 0;
    localparam int IRQ_POWER_RESTORED = 1;
    localparam int IRQ_LINK_CHANGE = 2;
    localparam int IRQ_BITS = 3;
    localparam int LINK_CTRL_TRAFFIC = 0;
    // reset values
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [23:0] RELAY_RESET = 24'h000000;
    // indicator timing
    localparam int CLK_MHZ = 200;
    localparam int BLINK_HALF_MS = 50;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam int PULSE_HOLD_MS = 200;
    localparam int PULSE_HOLD_CYCLES = PULSE_HOLD_MS * CLK_MHZ * 1000;
    localparam int SYNC_STAGES = 2;

    typedef enum {
        LNK_DETACHED,
        LNK_ENUMERATING,
        LNK_READY
    } rbo_link_e;

    // 1 = energize given bank polarity (active low drive inverts)
    function automatic logic [23:0] rbo_expand(input logic [3:0] bankBits);
        rbo_expand = ({24{bankBits[0]}} & BANK_FIRST_MASK)
                   | ({24{bankBits[1]}} & BANK_SECOND_MASK)
                   | ({24{bankBits[2]}} & BANK_CHIGH_MASK)
                   | ({24{bankBits[3]}} & BANK_CLOW_MASK);
    endfunction
endpackage

// [hdl/rbo_sync_if.sv]
// interface carrying raw pins into the synchroniser and clean levels out
`timescale 1ns/1ps
interface rbo_sync_if;
    logic [3:0] polStrapRaw;
    logic [3:0] ponStrapRaw;
    logic powerFaultRaw;
    logic attachedRaw;
    logic [3:0] polStrap;
    logic [3:0] ponStrap;
    logic powerFault;
    logic attached;
    modport pins (output polStrapRaw, ponStrapRaw, powerFaultRaw, attachedRaw,
                  input polStrap, ponStrap, powerFault, attached);
    modport sync (input polStrapRaw, ponStrapRaw, powerFaultRaw, attachedRaw,
                  output polStrap, ponStrap, powerFault, attached);
endinterface

// [hdl/rbo_pin_sync.sv]
// two-stage synchroniser for straps, supervisor and attach pins
`timescale 1ns/1ps
module rbo_pin_sync
    import rbo_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    rbo_sync_if.sync sif
);
    logic [9:0] stage1_r;
    logic [9:0] stage2_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            stage1_r <= 10'h000;
            stage2_r <= 10'h000;
        end else begin
            stage1_r <= {sif.polStrapRaw, sif.ponStrapRaw, sif.powerFaultRaw, sif.attachedRaw};
            stage2_r <= stage1_r;
        end
    end

    assign sif.polStrap = stage2_r[9:6];
    assign sif.ponStrap = stage2_r[5:2];
    assign sif.powerFault = stage2_r[1];
    assign sif.attached = stage2_r[0];
endmodule

// [hdl/rbo_relay_bank_ctrl.sv]
// relay bank output control: relay drive, straps, indicators, wishbone slave
//
// Notes on behaviour
// (RULE1) active high drive: bit 0 means relay released, written or read back
// (RULE2) active low drive: bit 0 means relay energized, written or read back
// (RULE3) straps apply per bank: relays 1-8, 9-16, 17-20, 21-24
// (RULE4) energize strap energizes whole bank at power-up, regardless of polarity
// (RULE5) release strap keeps whole bank de-energized at power-up
// (RULE6) polarity strap has no effect on power-up relay state
// (RULE7) link indicator glows steadily while attached to host or hub
// (RULE8) link indicator pulses during enumeration and while data moves
// (RULE9) power indicator lit with supply good, dark on supply fault
// (RULE10) link indicator always works; nothing can disable it
// (RULE11) polarity and power-on straps readable by host software
// (RULE12) bank holds strapped state until first host write, then data with polarity
// (RULE13) power indicator follows supervisor input, registered on mclk
`timescale 1ns/1ps
module rbo_relay_bank_ctrl
    import rbo_pkg::*;
#(
    parameter int BlinkHalfCycles = BLINK_HALF_CYCLES,
    parameter int PulseHoldCycles = PULSE_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // board pins
    input wire logic [3:0] polaritySelectStrap,
    input wire logic [3:0] powerOnLevelStrap,
    input wire logic supplyFault,
    input wire logic linkAttached,
    input wire logic linkEnumerating,
    output logic [23:0] relayEnergize,
    output logic powerGoodIndicator,
    output logic linkActivityIndicator,
    output logic irq
);
    rbo_sync_if sif();

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    assign sif.polStrapRaw = polaritySelectStrap;
    assign sif.ponStrapRaw = powerOnLevelStrap;
    assign sif.powerFaultRaw = supplyFault;
    assign sif.attachedRaw = linkAttached;

    rbo_pin_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .sif(sif)
    );

    // enumeration flag comes from the on-chip usb logic, same clock
    logic enumerating;
    assign enumerating = linkEnumerating;

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    // straps are only trusted once the synchroniser has filled
    logic [1:0] settle_r;
    logic strapsValid_r;
    logic [3:0] polLatched_r;
    logic [3:0] ponLatched_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            settle_r <= 2'h0;
            strapsValid_r <= 1'b0;
        end else if (!strapsValid_r) begin
            settle_r <= settle_r + 2'h1;
            if (settle_r == 2'(SYNC_STAGES)) begin
                strapsValid_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            polLatched_r <= 4'h0;
            ponLatched_r <= 4'h0;
        end else if (!strapsValid_r) begin
            polLatched_r <= sif.polStrap;
            ponLatched_r <= sif.ponStrap;
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic busReq;
    logic busWrite;
    logic [31:0] byteMask;
    logic ack_r;

    assign busReq = wb_cyc_i && wb_stb_i && !ack_r;
    assign busWrite = busReq && wb_we_i;
    assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ------------------------------------------------------------
    // relay data and drive
    // ------------------------------------------------------------
    logic [23:0] relayData_r;
    logic [23:0] relayData_nxt;
    logic [3:0] bankWritten_r;
    logic [3:0] bankTouched;
    logic [23:0] polMask;
    logic [23:0] ponMask;
    logic [23:0] writtenMask;

    // a bank counts as written when any byte lane covering it is enabled
    assign bankTouched = {wb_sel_i[2], wb_sel_i[2], wb_sel_i[1], wb_sel_i[0]};
    assign relayData_nxt = (relayData_r & ~byteMask[23:0]) | (wb_dat_i[23:0] & byteMask[23:0]);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            relayData_r <= RELAY_RESET;
            bankWritten_r <= 4'h0;
        end else if (busWrite && wb_adr_i == REG_RELAY_DATA && strapsValid_r) begin
            relayData_r <= relayData_nxt;
            bankWritten_r <= bankWritten_r | bankTouched;
        end
    end

    // (RULE3) per-bank strap spread
    assign polMask = rbo_expand(polLatched_r);
    assign ponMask = rbo_expand(ponLatched_r);
    assign writtenMask = rbo_expand(bankWritten_r);

    // (RULE1) (RULE2) polarity applied only to written banks
    // (RULE4) (RULE5) (RULE6) unwritten banks follow power-on strap only
    // (RULE12) strapped state until first write
    logic [23:0] drive_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            drive_r <= 24'h000000;
        end else begin
            drive_r <= (writtenMask & (relayData_r ^ polMask)) | (~writtenMask & ponMask);
        end
    end
    assign relayEnergize = drive_r;

    // readback in host logic sense: energized state mapped through polarity
    logic [23:0] relayReadback;
    assign relayReadback = drive_r ^ polMask;

    // ------------------------------------------------------------
    // power indicator
    // ------------------------------------------------------------
    // (RULE9) (RULE13) registered follower of the supervisor
    logic powerGood_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            powerGood_r <= 1'b0;
        end else begin
            powerGood_r <= !sif.powerFault;
        end
    end
    assign powerGoodIndicator = powerGood_r;

    // ------------------------------------------------------------
    // link indicator
    // ------------------------------------------------------------
    rbo_link_e linkState_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            linkState_r <= LNK_DETACHED;
        end else begin
            unique case (linkState_r)
                LNK_DETACHED: begin
                    if (sif.attached) begin
                        linkState_r <= LNK_ENUMERATING;
                    end
                end
                LNK_ENUMERATING: begin
                    if (!sif.attached) begin
                        linkState_r <= LNK_DETACHED;
                    end else if (!enumerating) begin
                        linkState_r <= LNK_READY;
                    end
                end
                LNK_READY: begin
                    if (!sif.attached) begin
                        linkState_r <= LNK_DETACHED;
                    end else if (enumerating) begin
                        linkState_r <= LNK_ENUMERATING;
                    end
                end
            endcase
        end
    end

    // traffic stretched so a single transfer gives a visible pulse
    logic [31:0] holdCnt_r;
    logic trafficSeen;
    assign trafficSeen = busReq || (busWrite && wb_adr_i == REG_LINK_CTRL
                                    && wb_sel_i[0] && wb_dat_i[LINK_CTRL_TRAFFIC]);
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            holdCnt_r <= 32'h0;
        end else if (trafficSeen) begin
            holdCnt_r <= 32'(PulseHoldCycles);
        end else if (holdCnt_r != 32'h0) begin
            holdCnt_r <= holdCnt_r - 32'h1;
        end
    end

    logic [31:0] blinkCnt_r;
    logic blink_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            blinkCnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (blinkCnt_r >= 32'(BlinkHalfCycles - 1)) begin
            blinkCnt_r <= 32'h0;
            blink_r <= !blink_r;
        end else begin
            blinkCnt_r <= blinkCnt_r + 32'h1;
        end
    end

    // (RULE7) (RULE8) steady when attached, pulsing on enumeration or traffic
    // (RULE10) no enable term exists on this output
    logic linkLed_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            linkLed_r <= 1'b0;
        end else if (linkState_r == LNK_DETACHED) begin
            linkLed_r <= 1'b0;
        end else if (linkState_r == LNK_ENUMERATING || holdCnt_r != 32'h0) begin
            linkLed_r <= blink_r;
        end else begin
            linkLed_r <= 1'b1;
        end
    end
    assign linkActivityIndicator = linkLed_r;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic powerGoodPrev_r;
    logic linkUpPrev_r;
    logic [IRQ_BITS-1:0] irqEvents;
    logic [IRQ_BITS-1:0] irqStatus_r;
    logic [IRQ_BITS-1:0] irqMask_r;
    logic [IRQ_BITS-1:0] irqClear;
    logic linkUp;
    logic eventsArmed_r;

    assign linkUp = linkState_r == LNK_READY;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            powerGoodPrev_r <= 1'b0;
            linkUpPrev_r <= 1'b0;
            eventsArmed_r <= 1'b0;
        end else begin
            powerGoodPrev_r <= powerGood_r;
            linkUpPrev_r <= linkUp;
            eventsArmed_r <= strapsValid_r;
        end
    end

    // edge history is meaningless until the synchroniser has filled,
    // otherwise every reset release would report a false power edge
    assign irqEvents[IRQ_POWER_FAULT] = eventsArmed_r && powerGoodPrev_r && !powerGood_r;
    assign irqEvents[IRQ_POWER_RESTORED] = eventsArmed_r && !powerGoodPrev_r && powerGood_r;
    assign irqEvents[IRQ_LINK_CHANGE] = eventsArmed_r && (linkUpPrev_r != linkUp);
    assign irqClear = (busWrite && wb_adr_i == REG_IRQ_STATUS && wb_sel_i[0])
                      ? wb_dat_i[IRQ_BITS-1:0] : '0;

    // a new event beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irqStatus_r <= '0;
        end else begin
            irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irqMask_r <= IRQ_MASK_RESET;
        end else if (busWrite && wb_adr_i == REG_IRQ_MASK && wb_sel_i[0]) begin
            irqMask_r <= wb_dat_i[IRQ_BITS-1:0];
        end
    end

    assign irq = |(irqStatus_r & irqMask_r);

    // ------------------------------------------------------------
    // read mux and ack
    // ------------------------------------------------------------
    logic [31:0] readData;
    always_comb begin
        readData = 32'h0;
        unique case (wb_adr_i)
            REG_RELAY_DATA: readData = {8'h00, relayReadback};
            // (RULE11) strap readback
            REG_STRAPS: readData = {24'h000000, ponLatched_r, polLatched_r};
            REG_STATUS: readData = {24'h000000, bankWritten_r, 2'h0, linkUp, powerGood_r};
            REG_IRQ_STATUS: readData = {29'h0, irqStatus_r};
            REG_IRQ_MASK: readData = {29'h0, irqMask_r};
            default: readData = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_r <= busReq;
            if (busReq && !wb_we_i) begin
                wb_dat_o <= readData;
            end
        end
    end
    assign wb_ack_o = ack_r;
endmodule

// [dv/rbo_ctrl_assertions.sv]
// port checker for the relay bank output control block
`timescale 1ns/1ps
module rbo_ctrl_checker
    import rbo_pkg::*;
#(
    parameter int BlinkHalfCycles = 4,
    parameter int PulseHoldCycles = 20
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] polaritySelectStrap,
    input wire logic [3:0] powerOnLevelStrap,
    input wire logic supplyFault,
    input wire logic linkAttached,
    input wire logic [23:0] relayEnergize,
    input wire logic powerGoodIndicator,
    input wire logic linkActivityIndicator
);
    // ----------
    // settle counter
    // ----------
    // strap latch moves the relays early on, so write tracing waits
    logic [3:0] upCnt_r;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            upCnt_r <= 4'h0;
        end else if (upCnt_r != 4'hf) begin
            upCnt_r <= upCnt_r + 4'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    strap_read_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == REG_STRAPS)
        |-> wb_dat_o[7:0] == {powerOnLevelStrap, polaritySelectStrap})
        else $error("strap readback wrong");
    unmapped_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h14)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    strap_power_up_a: assert property (upCnt_r == 4'h8 |-> relayEnergize == {{4{powerOnLevelStrap[3]}},
        {4{powerOnLevelStrap[2]}}, {8{powerOnLevelStrap[1]}}, {8{powerOnLevelStrap[0]}}})
        else $error("power-up relay state wrong");
    relay_write_only_a: assert property (upCnt_r == 4'hf && $changed(relayEnergize)
        |-> $past(wb_ack_o && wb_we_i && wb_adr_i == REG_RELAY_DATA))
        else $error("relays moved without a write");
    power_fault_dark_a: assert property (supplyFault [*4] |-> !powerGoodIndicator)
        else $error("power indicator lit on fault");
    power_good_lit_a: assert property (!supplyFault [*4] |-> powerGoodIndicator)
        else $error("power indicator dark with good supply");
    link_dark_a: assert property (!linkAttached [*5] |-> !linkActivityIndicator)
        else $error("link indicator lit while detached");
endmodule

bind rbo_relay_bank_ctrl rbo_ctrl_checker #(
    .BlinkHalfCycles(BlinkHalfCycles),
    .PulseHoldCycles(PulseHoldCycles)
) checker_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .polaritySelectStrap(polaritySelectStrap),
    .powerOnLevelStrap(powerOnLevelStrap),
    .supplyFault(supplyFault),
    .linkAttached(linkAttached),
    .relayEnergize(relayEnergize),
    .powerGoodIndicator(powerGoodIndicator),
    .linkActivityIndicator(linkActivityIndicator)
);

// [dv/rbo_host_model.sv]
// behavioural host side: attach, enumeration window, detach
`timescale 1ns/1ps
module rbo_host_model #(
    parameter int EnumCycles = 40
) (
    input wire logic mclk,
    input wire logic attachReq,
    output logic linkAttached,
    output logic linkEnumerating
);
    int enumCnt = 0;
    initial begin
        linkAttached = 1'b0;
        linkEnumerating = 1'b0;
    end
    // every fresh attach is followed by an enumeration window
    always @(posedge mclk) begin
        linkAttached <= attachReq;
        if (attachReq && !linkAttached) begin
            enumCnt <= EnumCycles;
        end else if (enumCnt > 0) begin
            enumCnt <= enumCnt - 1;
        end
        linkEnumerating <= attachReq && (enumCnt != 0);
    end
endmodule

// [dv/rbo_relay_bank_ctrl_tb_top.sv]
// self-checking bench for the relay bank output control block
`timescale 1ns/1ps
module rbo_relay_bank_ctrl_tb_top import rbo_pkg::*;;
    logic mclk = 1'b0;
    logic resetN = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [3:0] polStrap = 4'h0;
    logic [3:0] ponStrap = 4'h0;
    logic supplyFault = 1'b0;
    logic attachReq = 1'b1;
    logic [31:0] seed = 32'h0000c9c8;
    logic [31:0] wbDatO, rd, d;
    logic wbAck, linkAttached, linkEnum, powerGood, linkInd, irq;
    logic [23:0] relayEnergize;
    int miscompares = 0;
    int testsRun = 0;
    int hi;
    always #2.5 mclk = ~mclk;

    rbo_relay_bank_ctrl #(.BlinkHalfCycles(4), .PulseHoldCycles(20)) DUT (
        .mclk(mclk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .polaritySelectStrap(polStrap),
        .powerOnLevelStrap(ponStrap), .supplyFault(supplyFault),
        .linkAttached(linkAttached), .linkEnumerating(linkEnum),
        .relayEnergize(relayEnergize), .powerGoodIndicator(powerGood),
        .linkActivityIndicator(linkInd), .irq(irq));
    rbo_host_model #(.EnumCycles(40)) host (
        .mclk(mclk), .attachReq(attachReq), .linkAttached(linkAttached),
        .linkEnumerating(linkEnum));

    // ----------
    // helpers
    // ----------
    function automatic logic [23:0] bankWord(input logic [3:0] b);
        return {{4{b[3]}}, {4{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // request held until ack is sampled, released after that edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, a, dat, s};
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (n >= 50) chk("ackTimeout", 0, 1);
    endtask
    task automatic sampleInd();
        hi = 0;
        repeat (16) begin
            @(posedge mclk);
            hi += int'(linkInd === 1'b1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    initial begin
        // corners first: energize with no inversion, release with inversion
        for (int i = 0; i < 4; i++) begin
            d = xorshift();
            resetN <= 1'b0;
            polStrap <= (i == 0) ? 4'h0 : (i == 1) ? 4'hf : d[3:0];
            ponStrap <= (i == 0) ? 4'hf : (i == 1) ? 4'h0 : d[7:4];
            repeat (16) @(posedge mclk);
            resetN <= 1'b1;
            repeat (8) @(posedge mclk);
            chk("powerUp", relayEnergize, bankWord(ponStrap));
            wb(1'b0, REG_STRAPS, 32'h0, 4'hf);
            chk("straps", rd[7:0], {ponStrap, polStrap});
            wb(1'b0, REG_IRQ_STATUS, 32'h0, 4'hf);
            chk("noPwrEvt", rd[1:0], 2'h0);
            wb(1'b0, REG_RELAY_DATA, 32'h0, 4'hf);
            chk("preRead", rd[23:0], bankWord(ponStrap) ^ bankWord(polStrap));
            d = xorshift();
            wb(1'b1, REG_RELAY_DATA, d, 4'h1);
            @(posedge mclk);
            chk("bankOne", relayEnergize, (bankWord(ponStrap) & 24'hffff00)
                | ((d[23:0] ^ bankWord(polStrap)) & 24'h0000ff));
            wb(1'b0, REG_STATUS, 32'h0, 4'hf);
            chk("written", rd[7:4], 4'h1);
            d = xorshift();
            wb(1'b1, REG_RELAY_DATA, d, 4'h7);
            @(posedge mclk);
            chk("drive", relayEnergize, d[23:0] ^ bankWord(polStrap));
            wb(1'b0, REG_RELAY_DATA, 32'h0, 4'hf);
            chk("readBack", rd[23:0], d[23:0]);
            wb(1'b0, 8'h3c, 32'h0, 4'hf);
            chk("unmapped", rd, 32'h0);
        end
        supplyFault <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("pwrOff", powerGood, 1'b0);
        supplyFault <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("pwrOn", powerGood, 1'b1);
        wb(1'b0, REG_IRQ_STATUS, 32'h0, 4'hf);
        chk("irqEvents", rd[1:0], 2'h3);
        chk("irqMasked", irq, 1'b0);
        wb(1'b1, REG_IRQ_MASK, 32'h1, 4'hf);
        @(posedge mclk);
        chk("irqRaised", irq, 1'b1);
        wb(1'b1, REG_IRQ_STATUS, 32'h1, 4'hf);
        @(posedge mclk);
        chk("irqCleared", irq, 1'b0);
        attachReq <= 1'b0;
        repeat (10) @(posedge mclk);
        sampleInd();
        chk("detached", hi, 0);
        attachReq <= 1'b1;
        repeat (8) @(posedge mclk);
        sampleInd();
        chk("enumBlink", hi > 0 && hi < 16, 1'b1);
        repeat (100) @(posedge mclk);
        sampleInd();
        chk("steady", hi, 16);
        wb(1'b1, REG_LINK_CTRL, 32'h1, 4'hf);
        sampleInd();
        chk("trafficBlink", hi > 0 && hi < 16, 1'b1);
        finish_test();
    end
endmodule
